// ### core/regfile_defs.svh
// constants for the cpu working-register file and data-space map
// assumes inclusion by bare name from core design files
`ifndef REGFILE_DEFS_SVH
`define REGFILE_DEFS_SVH
// working registers
`define RF_NUM_REGS 32
`define RF_PTR_BASE 5'h1A
// data-space map
`define DS_REG_LAST 16'h001F
`define DS_IO_FIRST 16'h0020
`define DS_IO_LAST 16'h005F
`define DS_SRAM_FIRST 16'h0060
`define DS_SRAM_LAST 16'h00DF
`define IO_NUM_LOCS 64
`define SRAM_NUM_BYTES 128
// reset qualification
`define RST_MIN_CYCLES 2
`define RST_CNT_W 2
// reset values
`define RF_RESET_VAL 8'h00
`define PC_RESET_VAL 16'h0000
`define NOP_WORD 16'h0000
`endif

// ### core/regfile_pkg.sv
// types shared by the register file core
// assumes the defs header is included where constants are needed
package regfile_pkg;
	// alu operand source selection
	typedef enum logic [1:0] {
		OPSEL_REG_REG = 2'b00,
		OPSEL_IMM_REG = 2'b01,
		OPSEL_SINGLE = 2'b10
	} opsel_t;
	// data-space region decode
	typedef enum logic [1:0] {
		REGION_REG = 2'b00,
		REGION_IO = 2'b01,
		REGION_SRAM = 2'b10,
		REGION_NONE = 2'b11
	} region_t;
	// core run state
	typedef enum logic [1:0] {
		RUN_ACTIVE = 2'b00,
		RUN_IDLE = 2'b01,
		RUN_PDOWN = 2'b10,
		RUN_RESET = 2'b11
	} run_t;
endpackage

// ### core/sram_byte_mem.sv
// byte-wide data memory with registered read data
// assumes a single clock and a synchronous clock enable
`timescale 1ns/1ps
module sram_byte_mem #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	// clock and enable
	input wire logic clk_sys,
	input wire logic ce,
	// access port
	input wire logic [AW-1:0] addr,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data_r
);
	// storage array, contents kept through reset
	logic [7:0] mem [DEPTH];
	// ***********************
	// write and registered read
	// ***********************
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			if (wr_en) begin
				mem[addr] <= wr_data;
			end
			rd_data_r <= mem[addr];
		end
	end
endmodule // sram_byte_mem

// ### core/reset_qual.sv
// qualifies the external reset: low for a minimum number of cycles
// assumes the reset pin is asynchronous to clk_sys
`timescale 1ns/1ps
`include "regfile_defs.svh"
module reset_qual (
	// clock and enable
	input wire logic clk_sys,
	input wire logic ce,
	// raw pin and qualified result
	input wire logic ext_rst_n,
	output logic core_rst_r
);
	// three-stage synchroniser
	logic s1_r, s2_r, s3_r;
	logic [`RST_CNT_W-1:0] cnt_r, cnt_nxt;
	logic core_rst_nxt;
	// ***********************
	// synchroniser, stage one read only by stage two
	// ***********************
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			s1_r <= ext_rst_n;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end
	// ***********************
	// count low cycles once stages two and three agree
	// ***********************
	always_comb begin
		cnt_nxt = cnt_r;
		core_rst_nxt = core_rst_r;
		if (!s2_r && !s3_r) begin
			if (cnt_r != `RST_CNT_W'(`RST_MIN_CYCLES - 1)) begin
				cnt_nxt = cnt_r + `RST_CNT_W'(1);
			end else begin
				core_rst_nxt = 1'b1;
			end
		end else if (s2_r && s3_r) begin
			cnt_nxt = '0;
			core_rst_nxt = 1'b0;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (ce) begin
			cnt_r <= cnt_nxt;
			core_rst_r <= core_rst_nxt;
		end
	end
endmodule // reset_qual

// ### core/cpu_regfile.sv
// cpu working-register file, pointer pairs, data-space map and fetch stage
// assumes decoder/alu on clk_sys; peripherals answer the io window
//
// Overview of operation
// - thirty-two byte registers, single-cycle access
// - two operands out, result back, one cycle
// - six registers form three 16-bit pointers
// - third pointer addresses program-memory constant lookups
// - reg-reg, immediate-reg and single-reg operand forms
// - data addresses 00-1F reach working registers
// - 64 io locations, also at 20-5F
// - separate buses, two-stage fetch/execute pipeline
// - reset pin low three cycles resets
// - idle stops cpu, memory and peripherals run
// - power-down keeps registers, halts until wake
// - pointers built from registers 26 to 31
// - 128 sram bytes follow first 96 locations
`timescale 1ns/1ps
`include "regfile_defs.svh"
module cpu_regfile #(
	parameter int PC_W = 16
) (
	// clock, enable, reset
	input wire logic clk_sys,
	input wire logic ce,
	input wire logic rst_n,
	input wire logic ext_rst_n,
	// alu operand ports
	input wire logic [4:0] rd_sel,
	input wire logic [4:0] rr_sel,
	input wire regfile_pkg::opsel_t op_sel,
	input wire logic [7:0] imm_val,
	output logic [7:0] op_a,
	output logic [7:0] op_b,
	// alu result write-back
	input wire logic res_we,
	input wire logic [7:0] res_val,
	// pointer pair write (post-increment, pre-decrement)
	input wire logic ptr_we,
	input wire logic [1:0] ptr_sel,
	input wire logic [15:0] ptr_val,
	output logic [15:0] ptr_x,
	output logic [15:0] ptr_y,
	output logic [15:0] ptr_z,
	// constant lookup address
	output logic [15:0] lpm_addr,
	// data-space access
	input wire logic ds_req,
	input wire logic ds_we,
	input wire logic [15:0] ds_addr,
	input wire logic [7:0] ds_wdata,
	output logic [7:0] ds_rdata_r,
	// io window to peripherals
	output logic io_req,
	output logic io_we,
	output logic [5:0] io_addr,
	output logic [7:0] io_wdata,
	input wire logic [7:0] io_rdata,
	// program memory fetch
	output logic [PC_W-1:0] pm_addr,
	input wire logic [15:0] pm_data,
	input wire logic redirect,
	input wire logic [PC_W-1:0] redirect_pc,
	output logic [15:0] instr_r,
	output logic instr_valid_r,
	// power modes
	input wire logic sleep_idle,
	input wire logic sleep_pdown,
	input wire logic wake_irq,
	output logic cpu_run,
	output logic osc_run,
	output logic core_rst
);
	// ***********************
	// helpers
	// ***********************
	function automatic regfile_pkg::region_t region_of(input logic [15:0] a);
		if (a <= `DS_REG_LAST) region_of = regfile_pkg::REGION_REG;
		else if (a <= `DS_IO_LAST) region_of = regfile_pkg::REGION_IO;
		else if (a <= `DS_SRAM_LAST) region_of = regfile_pkg::REGION_SRAM;
		else region_of = regfile_pkg::REGION_NONE;
	endfunction
	// pointer pair from the register array
	function automatic logic [15:0] pair_of(input logic [7:0] lo, input logic [7:0] hi);
		pair_of = {hi, lo};
	endfunction
	// ***********************
	// reset qualification
	// ***********************
	logic qual_rst;
	reset_qual u_rq (
		.clk_sys(clk_sys),
		.ce(ce),
		.ext_rst_n(ext_rst_n),
		.core_rst_r(qual_rst)
	);
	logic any_rst;
	assign any_rst = !rst_n || qual_rst;
	assign core_rst = any_rst;
	// ***********************
	// run state
	// ***********************
	regfile_pkg::run_t run_r, run_nxt;
	always_comb begin
		run_nxt = run_r;
		unique case (run_r)
			regfile_pkg::RUN_RESET: run_nxt = regfile_pkg::RUN_ACTIVE;
			regfile_pkg::RUN_ACTIVE: begin
				if (sleep_pdown) run_nxt = regfile_pkg::RUN_PDOWN;
				else if (sleep_idle) run_nxt = regfile_pkg::RUN_IDLE;
			end
			regfile_pkg::RUN_IDLE: if (wake_irq) run_nxt = regfile_pkg::RUN_ACTIVE;
			regfile_pkg::RUN_PDOWN: if (wake_irq) run_nxt = regfile_pkg::RUN_ACTIVE;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (any_rst) run_r <= regfile_pkg::RUN_RESET;
		else if (ce) run_r <= run_nxt;
	end
	// cpu executes only when active; oscillator stops in power-down
	assign cpu_run = (run_r == regfile_pkg::RUN_ACTIVE);
	assign osc_run = (run_r != regfile_pkg::RUN_PDOWN);
	logic mem_run;
	assign mem_run = ce && osc_run; // memory keeps working in idle
	// ***********************
	// register array
	// ***********************
	logic [7:0] regs_r [`RF_NUM_REGS];
	logic [7:0] regs_nxt [`RF_NUM_REGS];
	logic ds_reg_hit;
	assign ds_reg_hit = ds_req && region_of(ds_addr) == regfile_pkg::REGION_REG;
	always_comb begin
		for (int i = 0; i < `RF_NUM_REGS; i++) regs_nxt[i] = regs_r[i];
		if (cpu_run) begin
			if (ds_reg_hit && ds_we) regs_nxt[ds_addr[4:0]] = ds_wdata;
			if (ptr_we && ptr_sel != 2'h3) begin // only three pairs exist, no wrap to r0
				// pair low byte then high byte
				regs_nxt[`RF_PTR_BASE + {2'b00, ptr_sel, 1'b0}] = ptr_val[7:0];
				regs_nxt[`RF_PTR_BASE + {2'b00, ptr_sel, 1'b1}] = ptr_val[15:8];
			end
			if (res_we) regs_nxt[rd_sel] = res_val;
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < `RF_NUM_REGS; i++) regs_r[i] <= `RF_RESET_VAL;
		end else if (ce) begin
			for (int i = 0; i < `RF_NUM_REGS; i++) regs_r[i] <= regs_nxt[i];
		end
	end
	// operands read combinationally for same-cycle execute
	always_comb begin
		op_a = regs_r[rd_sel];
		unique case (op_sel)
			regfile_pkg::OPSEL_IMM_REG: op_b = imm_val;
			regfile_pkg::OPSEL_SINGLE: op_b = 8'h00;
			default: op_b = regs_r[rr_sel];
		endcase
	end
	// pointers from the top six registers
	assign ptr_x = pair_of(regs_r[26], regs_r[27]);
	assign ptr_y = pair_of(regs_r[28], regs_r[29]);
	assign ptr_z = pair_of(regs_r[30], regs_r[31]);
	assign lpm_addr = ptr_z;
	// ***********************
	// io window and sram
	// ***********************
	logic io_hit, sram_hit;
	logic [15:0] io_off, sram_off;
	assign io_off = ds_addr - `DS_IO_FIRST;
	assign sram_off = ds_addr - `DS_SRAM_FIRST;
	assign io_hit = ds_req && region_of(ds_addr) == regfile_pkg::REGION_IO;
	assign sram_hit = ds_req && region_of(ds_addr) == regfile_pkg::REGION_SRAM;
	assign io_req = io_hit && cpu_run;
	assign io_we = io_hit && ds_we && cpu_run;
	assign io_addr = io_off[5:0];
	assign io_wdata = ds_wdata;
	logic [7:0] sram_rd;
	sram_byte_mem #(
		.DEPTH(`SRAM_NUM_BYTES),
		.AW(7)
	) u_sram (
		.clk_sys(clk_sys),
		.ce(mem_run),
		.addr(sram_off[6:0]),
		.wr_en(sram_hit && ds_we && cpu_run),
		.wr_data(ds_wdata),
		.rd_data_r(sram_rd)
	);
	// read-data select, registered to align with sram latency
	regfile_pkg::region_t rsel_r, rsel_nxt;
	logic [7:0] hold_r, hold_nxt;
	always_comb begin
		rsel_nxt = rsel_r;
		hold_nxt = hold_r;
		if (ds_req) begin
			rsel_nxt = region_of(ds_addr);
			hold_nxt = (rsel_nxt == regfile_pkg::REGION_IO) ? io_rdata : regs_r[ds_addr[4:0]];
		end
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsel_r <= regfile_pkg::REGION_NONE;
			hold_r <= 8'h00;
		end else if (ce) begin
			rsel_r <= rsel_nxt;
			hold_r <= hold_nxt;
		end
	end
	always_comb begin
		unique case (rsel_r)
			regfile_pkg::REGION_SRAM: ds_rdata_r = sram_rd;
			regfile_pkg::REGION_NONE: ds_rdata_r = 8'h00;
			default: ds_rdata_r = hold_r;
		endcase
	end
	// ***********************
	// fetch pipeline
	// ***********************
	logic [PC_W-1:0] pc_r, pc_nxt;
	logic [15:0] instr_nxt;
	logic ivalid_nxt;
	always_comb begin
		pc_nxt = pc_r;
		instr_nxt = instr_r;
		ivalid_nxt = instr_valid_r;
		if (cpu_run) begin
			if (redirect) begin
				pc_nxt = redirect_pc;
				instr_nxt = `NOP_WORD;
				ivalid_nxt = 1'b0;
			end else begin
				pc_nxt = pc_r + PC_W'(1);
				instr_nxt = pm_data;
				ivalid_nxt = 1'b1;
			end
		end
	end
	always_ff @(posedge clk_sys) begin
		if (any_rst) begin
			pc_r <= PC_W'(`PC_RESET_VAL);
			instr_r <= `NOP_WORD;
			instr_valid_r <= 1'b0;
		end else if (ce) begin
			pc_r <= pc_nxt;
			instr_r <= instr_nxt;
			instr_valid_r <= ivalid_nxt;
		end
	end
	assign pm_addr = pc_r;
	// ***********************
	// checks
	// ***********************
	property p_wb_same_cycle;
		@(posedge clk_sys) disable iff (!rst_n)
		ce && cpu_run && res_we && !ptr_we |=> regs_r[$past(rd_sel)] == $past(res_val);
	endproperty
	a_wb_same_cycle: assert property (p_wb_same_cycle) else $error("result not written");
	property p_ptr_z;
		@(posedge clk_sys) disable iff (!rst_n) lpm_addr == {regs_r[31], regs_r[30]};
	endproperty
	a_ptr_z: assert property (p_ptr_z) else $error("lookup pointer wrong");
	property p_io_map;
		@(posedge clk_sys) disable iff (!rst_n)
		io_req |-> ds_addr >= `DS_IO_FIRST && ds_addr <= `DS_IO_LAST;
	endproperty
	a_io_map: assert property (p_io_map) else $error("io decode wrong");
	property p_fetch_adv;
		@(posedge clk_sys) disable iff (any_rst)
		ce && cpu_run && !redirect |=> pm_addr == $past(pm_addr) + PC_W'(1);
	endproperty
	a_fetch_adv: assert property (p_fetch_adv) else $error("pc did not advance");
	sequence s_redirect;
		ce && cpu_run && redirect;
	endsequence
	property p_flush;
		@(posedge clk_sys) disable iff (any_rst)
		s_redirect |=> !instr_valid_r && pm_addr == $past(redirect_pc);
	endproperty
	a_flush: assert property (p_flush) else $error("prefetch not discarded");
	property p_idle_hold;
		@(posedge clk_sys) disable iff (any_rst)
		run_r == regfile_pkg::RUN_IDLE && ce |=> pm_addr == $past(pm_addr);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("cpu ran in idle");
	property p_pdown_keep;
		@(posedge clk_sys) disable iff (any_rst)
		// a taken wake leaves power-down, so only a held power-down must keep the oscillator off
		run_r == regfile_pkg::RUN_PDOWN && !(ce && wake_irq)
		|=> ptr_z == $past(ptr_z) && !osc_run [*1];
	endproperty
	a_pdown_keep: assert property (p_pdown_keep) else $error("power-down lost state");
	property p_regmap;
		@(posedge clk_sys) disable iff (!rst_n)
		ce && cpu_run && ds_reg_hit && ds_we && !res_we && !ptr_we
		|=> regs_r[$past(ds_addr[4:0])] == $past(ds_wdata);
	endproperty
	a_regmap: assert property (p_regmap) else $error("register map write lost");
endmodule // cpu_regfile

// ### test/partner_model.sv
// program memory and io peripheral model facing the register file
// assumes combinational answers within the same clk_sys cycle
`timescale 1ns/1ps
module partner_model (
	// program memory side
	input wire logic [15:0] pm_addr,
	output logic [15:0] pm_data,
	// io window side
	input wire logic io_req,
	input wire logic [5:0] io_addr,
	output logic [7:0] io_rdata
);
	// rom word is a scramble of its own address
	assign pm_data = pm_addr ^ 16'hC3A5;
	// io answers only while selected, inverted pattern otherwise
	assign io_rdata = io_req ? {2'h2, io_addr} : ~{2'h2, io_addr};
endmodule // partner_model

// ### test/cpu_register_file_data_map_tb.sv
// self-checking bench for the working-register file and data map
// assumes partner_model answers fetch and io; inputs change at negedge
`timescale 1ns/1ps
module cpu_register_file_data_map_tb;
	// stimulus
	logic clk_sys = 1'h0, rst_n = 1'h0, ext_rst_n = 1'h1, res_we = 1'h0, ptr_we = 1'h0;
	logic ds_req = 1'h0, ds_we = 1'h0, redirect = 1'h0, ce = 1'h1;
	logic sleep_idle = 1'h0, sleep_pdown = 1'h0, wake_irq = 1'h0;
	logic [4:0] rd_sel = 5'h00, rr_sel = 5'h00;
	logic [7:0] imm_val = 8'h00, res_val = 8'h00, ds_wdata = 8'h00;
	logic [1:0] ptr_sel = 2'h0;
	logic [15:0] ptr_val = 16'h0000, ds_addr = 16'h0000, redirect_pc = 16'h0000;
	regfile_pkg::opsel_t op_sel = regfile_pkg::OPSEL_REG_REG;
	// observed
	logic [7:0] op_a, op_b, ds_rdata_r, io_wdata, io_rdata;
	logic [15:0] ptr_x, ptr_y, ptr_z, lpm_addr, pm_addr, pm_data, instr_r;
	logic io_req, io_we, instr_valid_r, cpu_run, osc_run, core_rst;
	logic [5:0] io_addr;
	int errors = 0, n_checks = 0;

	always #2 clk_sys = ~clk_sys;

	cpu_regfile #(.PC_W(16)) cpu_regfile_inst (.clk_sys(clk_sys), .ce(ce), .rst_n(rst_n),
		.ext_rst_n(ext_rst_n), .rd_sel(rd_sel), .rr_sel(rr_sel), .op_sel(op_sel),
		.imm_val(imm_val), .op_a(op_a), .op_b(op_b), .res_we(res_we), .res_val(res_val),
		.ptr_we(ptr_we), .ptr_sel(ptr_sel), .ptr_val(ptr_val), .ptr_x(ptr_x), .ptr_y(ptr_y),
		.ptr_z(ptr_z), .lpm_addr(lpm_addr), .ds_req(ds_req), .ds_we(ds_we), .ds_addr(ds_addr),
		.ds_wdata(ds_wdata), .ds_rdata_r(ds_rdata_r), .io_req(io_req), .io_we(io_we),
		.io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata), .pm_addr(pm_addr),
		.pm_data(pm_data), .redirect(redirect), .redirect_pc(redirect_pc), .instr_r(instr_r),
		.instr_valid_r(instr_valid_r), .sleep_idle(sleep_idle), .sleep_pdown(sleep_pdown),
		.wake_irq(wake_irq), .cpu_run(cpu_run), .osc_run(osc_run), .core_rst(core_rst));

	partner_model partner_model_inst (.pm_addr(pm_addr), .pm_data(pm_data), .io_req(io_req),
		.io_addr(io_addr), .io_rdata(io_rdata));

	// compare one value, count and report
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// wait whole cycles, landing on falling edges
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// counts and verdict
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// one data-space access, io window checked while it is requested
	task automatic ds(input logic we, input logic [15:0] a, input logic [7:0] d);
		ds_req = 1'h1;
		ds_we = we;
		ds_addr = a;
		ds_wdata = d;
		#1 chk("io_req", (a >= 16'h0020 && a <= 16'h005F), io_req);
		if (io_req === 1'h1) chk("io_addr", a - 16'h0020, io_addr);
		cyc(1);
		// strobe stays up for back-to-back accesses; the caller releases it
	endtask

	// back-to-back writes to all registers, operand forms, same-cycle write-back
	task automatic t_regs;
		res_we = 1'h1;
		for (int i = 0; i < 32; i++) begin
			rd_sel = i[4:0];
			res_val = 8'h40 + i[7:0];
			cyc(1);
		end
		res_we = 1'h0;
		for (int i = 0; i < 32; i++) begin
			rd_sel = i[4:0];
			rr_sel = 5'h1F - i[4:0];
			#1 chk("op_a", 8'h40 + i[7:0], op_a);
			chk("op_b", 8'h5F - i[7:0], op_b);
			cyc(1);
		end
		rd_sel = 5'h05;
		cyc(1);
		res_val = op_a + 8'h01;
		res_we = 1'h1;
		cyc(1);
		res_we = 1'h0;
		op_sel = regfile_pkg::OPSEL_IMM_REG;
		imm_val = 8'h9C;
		#1 chk("op_a rmw", 8'h46, op_a);
		chk("op_b imm", 8'h9C, op_b);
		cyc(1);
		op_sel = regfile_pkg::OPSEL_SINGLE;
		#1 chk("op_b single", 8'h00, op_b);
		cyc(1);
		op_sel = regfile_pkg::OPSEL_REG_REG;
		$display("test regs done");
	endtask

	// pointer pairs from the top six registers
	task automatic t_ptr;
		ptr_we = 1'h1;
		for (int p = 0; p < 3; p++) begin
			ptr_sel = p[1:0];
			ptr_val = 16'h1234 + 16'h1111 * p[15:0];
			cyc(1);
		end
		ptr_we = 1'h0;
		rd_sel = 5'h1A;
		rr_sel = 5'h1F;
		#1 chk("ptr_x", 16'h1234, ptr_x);
		chk("ptr_y", 16'h2345, ptr_y);
		chk("ptr_z", 16'h3456, ptr_z);
		chk("lpm_addr", 16'h3456, lpm_addr);
		chk("x low", 8'h34, op_a);
		chk("z high", 8'h34, op_b);
		cyc(1);
		$display("test ptr done");
	endtask

	// register, io and sram windows of the data space
	task automatic t_ds;
		rd_sel = 5'h07;
		ds(1'h1, 16'h0007, 8'hE1);
		chk("reg via ds", 8'hE1, op_a);
		ds(1'h0, 16'h001C, 8'h00);
		chk("ds reg rd", 8'h45, ds_rdata_r);
		ds(1'h0, 16'h005F, 8'h00);
		chk("ds io rd", 8'hBF, ds_rdata_r);
		ds(1'h1, 16'h0060, 8'h11);
		ds(1'h1, 16'h00DF, 8'h22);
		ds(1'h0, 16'h0060, 8'h00);
		chk("sram lo", 8'h11, ds_rdata_r);
		ds(1'h0, 16'h00DF, 8'h00);
		chk("sram hi", 8'h22, ds_rdata_r);
		ds(1'h0, 16'h00E0, 8'h00);
		chk("beyond map", 8'h00, ds_rdata_r);
		ds_req = 1'h0;
		ds_we = 1'h0;
		$display("test ds done");
	endtask

	// fetch one word per cycle, redirect refills
	task automatic t_fetch;
		logic [15:0] pa;
		for (int i = 0; i < 6; i++) begin
			pa = pm_addr;
			cyc(1);
			chk("instr_valid", 1'h1, instr_valid_r);
			chk("instr", pa ^ 16'hC3A5, instr_r);
			chk("pc step", pa + 16'h0001, pm_addr);
		end
		redirect = 1'h1;
		redirect_pc = 16'h0200;
		cyc(1);
		redirect = 1'h0;
		chk("pc redirect", 16'h0200, pm_addr);
		chk("flushed", 1'h0, instr_valid_r);
		cyc(1);
		chk("refill", 16'h0200 ^ 16'hC3A5, instr_r);
		$display("test fetch done");
	endtask

	// idle and power-down, wake by interrupt
	task automatic t_sleep;
		sleep_idle = 1'h1;
		cyc(1);
		chk("idle run", 1'h0, cpu_run);
		chk("idle osc", 1'h1, osc_run);
		// data memory keeps answering while the cpu idles
		ds(1'h0, 16'h0060, 8'h00);
		ds_req = 1'h0;
		chk("idle sram", 8'h11, ds_rdata_r);
		rd_sel = 5'h05;
		res_val = 8'hFF;
		res_we = 1'h1;
		cyc(1);
		res_we = 1'h0;
		sleep_idle = 1'h0;
		chk("idle no write", 8'h46, op_a);
		wake_irq = 1'h1;
		cyc(1);
		wake_irq = 1'h0;
		chk("wake run", 1'h1, cpu_run);
		sleep_pdown = 1'h1;
		cyc(1);
		sleep_pdown = 1'h0;
		cyc(3);
		chk("pdown osc", 1'h0, osc_run);
		chk("pdown run", 1'h0, cpu_run);
		wake_irq = 1'h1;
		cyc(1);
		wake_irq = 1'h0;
		cyc(1);
		chk("pdown wake", 1'h1, cpu_run);
		chk("pdown kept", 8'h46, op_a);
		$display("test sleep done");
	endtask

	// clock enable low freezes fetch and write-back
	task automatic t_ce;
		logic [15:0] pa;
		pa = pm_addr;
		ce = 1'h0;
		rd_sel = 5'h05;
		res_val = 8'h77;
		res_we = 1'h1;
		cyc(2);
		chk("ce pc hold", pa, pm_addr);
		res_we = 1'h0;
		ce = 1'h1;
		cyc(1);
		chk("ce no write", 8'h46, op_a);
		$display("test ce done");
	endtask

	// reset pin: short pulse ignored, long pulse restarts fetch
	task automatic t_extrst;
		int k;
		ext_rst_n = 1'h0;
		cyc(1);
		ext_rst_n = 1'h1;
		for (k = 0; k < 10; k++) begin
			cyc(1);
			chk("short pulse", 1'h0, core_rst);
		end
		ext_rst_n = 1'h0;
		for (k = 0; k < 12 && core_rst !== 1'h1; k++) cyc(1);
		chk("pin reset", 1'h1, core_rst);
		if (core_rst !== 1'h1) summarize();
		cyc(2);
		ext_rst_n = 1'h1;
		for (k = 0; k < 12 && core_rst !== 1'h0; k++) cyc(1);
		chk("pin release", 1'h0, core_rst);
		if (core_rst !== 1'h0) summarize();
		chk("pc restart", 16'h0000, pm_addr);
		$display("test extrst done");
	endtask

	initial begin
		cyc(3);
		rst_n = 1'h1;
		cyc(2);
		t_regs();
		t_ptr();
		t_ds();
		t_fetch();
		t_sleep();
		t_ce();
		t_extrst();
		summarize();
	end
endmodule // cpu_register_file_data_map_tb
